/* File: core/spi_emu.sv */
// Pin-level serial interface emulation: a master that makes
// its own clock from a periodic timer and a slave that runs
// on the clock of an external master.
// Assumes chip select is handled outside; TX_DATA_I and
// SLV_TX_DATA_I come from logic on CLK_SYS_I.
//
// Operation
// RULE1: Master step timer fires at 9600 Hz.
// RULE2: Each step drives next of alternating 1,0.
// RULE3: Phase 1, polarity 0 on both ends.
// RULE4: Each clock step links to receive step. Here only the falling (odd) steps sample the input.
// RULE5: Completed iteration count links to transmit step.
// RULE6: Receive step fills eight received parallel bits.
// RULE7: Transmit step sends eight parallel output bits.
// RULE8: Every frame carries eight data bits.
// RULE9: Master transfer begins when timer gets enabled.
// RULE10: After frame, control step disables the timer.
// RULE11: Software starts; stop character stops automatically.
// RULE12: Chip select driven by software, not here.
// RULE13: Slave steps on each external clock edge.
// RULE14: Slave first edge presents output bit first.
// RULE15: Slave clock launches transmit then receive steps.
// RULE16: Most significant bit first, one per period.
// RULE17: Counters reload after each eight-bit frame.
`include "spi_emu_defs.svh"

module spi_emu #(
    // Step timer period in system clocks
    parameter int unsigned STEP_CYCLES = `SPI_STEP_CYC
) (
    // System clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // Master control from logic on CLK_SYS_I
    input wire logic START_I,
    input wire logic [7:0] STOP_CHAR_I,
    input wire logic [7:0] TX_DATA_I,
    output logic TX_TAKE_O,
    output logic [7:0] RX_DATA_O,
    output logic RX_VALID_O,
    output logic BUSY_O,
    // Master pins
    output logic MST_SCK_O,
    output logic MST_MOSI_O,
    input wire logic MST_MISO_I,
    // Slave parallel side
    input wire logic SLV_TX_LOAD_I,
    input wire logic [7:0] SLV_TX_DATA_I,
    output logic [7:0] SLV_RX_DATA_O,
    output logic SLV_RX_VALID_O,
    // Slave pins, on the external master's clock
    input wire logic SLV_SCK_I,
    input wire logic SLV_MOSI_I,
    output logic SLV_MISO_O
);
    import spi_emu_pkg::*;

    // ======================================================
    // Declarations

    // Timer reload value cut to the counter width
    localparam logic [`SPI_TICK_W-1:0] TICK_RELOAD =
        `SPI_TICK_W'(STEP_CYCLES - 1);

    sys_state_t s_q; // Registered system state
    sys_state_t s_d; // Next system state

    logic [7:0] link_rx_word; // Slave byte, link domain
    logic link_done_tgl;      // Slave frame toggle

    logic step_evt;  // Timer has expired this cycle
    logic rise_step; // Step that raises the clock
    logic [7:0] rx_next; // Receive shifter after sample

    // ======================================================
    // Decoding of the step index

    // Even steps raise the clock, odd steps lower it
    function automatic logic is_rise(input logic [3:0] st);
        is_rise = ~st[0];
    endfunction

    // Last step of an eight-bit frame
    function automatic logic is_last(input logic [3:0] st);
        is_last = (st == `SPI_LAST_STEP);
    endfunction

    // ======================================================
    // Slave link engine on the external clock
    spi_emu_slave_link u_link (
        .sck_i(SLV_SCK_I),
        .rst_i(RST_I),
        .mosi_i(SLV_MOSI_I),
        .miso_o(SLV_MISO_O),
        .tx_word_i(s_q.slv_hold),
        .rx_word_o(link_rx_word),
        .done_tgl_o(link_done_tgl)
    );

    // ======================================================
    // Step decode helpers
    always_comb begin
        // Timer expiry only counts while enabled
        step_evt = (s_q.mst == M_RUN) && (s_q.tick == '0); // RULE1
        rise_step = is_rise(s_q.step);
        // Sample from the second sync stage only
        rx_next = {s_q.rx_sh[6:0], s_q.miso_s2};
    end

    // ======================================================
    // Next state of the system domain
    always_comb begin
        s_d = s_q;

        // Pulses last one cycle
        s_d.rx_valid = 1'b0;
        s_d.tx_take = 1'b0;
        s_d.slv_rx_valid = 1'b0;

        // Two-stage synchroniser for the master input pin
        s_d.miso_s1 = MST_MISO_I;
        s_d.miso_s2 = s_q.miso_s1;

        // Two stages plus edge reference for slave toggle
        s_d.tgl_s1 = link_done_tgl;
        s_d.tgl_s2 = s_q.tgl_s1;
        s_d.tgl_s3 = s_q.tgl_s2;

        // --------------------------------------------------
        // Slave side: hand over a finished byte
        if (s_q.tgl_s2 != s_q.tgl_s3) begin
            // Link word is stable for a whole frame now
            s_d.slv_rx = link_rx_word; // RULE6
            s_d.slv_rx_valid = 1'b1;
        end
        // Load the byte for the next slave frame
        if (SLV_TX_LOAD_I) begin
            s_d.slv_hold = SLV_TX_DATA_I; // RULE7
        end

        // --------------------------------------------------
        // Master side sequencing
        unique case (s_q.mst)
            M_IDLE: begin
                // Clock rests at the idle polarity
                s_d.sck = `SPI_CPOL; // RULE3
                s_d.busy = 1'b0;
                if (START_I) begin
                    // Control step enables the timer
                    s_d.mst = M_RUN; // RULE9 RULE11
                    s_d.busy = 1'b1;
                    s_d.tick = TICK_RELOAD;
                    s_d.step = 4'h0;
                    s_d.tx_sh = TX_DATA_I;
                    s_d.last_tx = TX_DATA_I;
                    s_d.tx_take = 1'b1;
                end
            end
            M_RUN: begin
                if (!step_evt) begin
                    // Timer counts toward the next step
                    s_d.tick = s_q.tick - `SPI_TICK_W'(1);
                end else begin
                    // Timer restarts for the next step
                    s_d.tick = TICK_RELOAD; // RULE1
                    s_d.step = s_q.step + 4'h1;
                    // Clock takes the next pattern value
                    s_d.sck = rise_step; // RULE2
                    if (rise_step) begin
                        // Leading edge shifts out, MSB first
                        s_d.mosi = s_q.tx_sh[7]; // RULE5 RULE16
                        s_d.tx_sh = {s_q.tx_sh[6:0], 1'b0};
                    end else begin
                        // Trailing edge samples the input
                        s_d.rx_sh = rx_next; // RULE4 RULE3
                    end
                    if (is_last(s_q.step)) begin
                        // Eighth bit closes the frame
                        s_d.rx_data = rx_next; // RULE6 RULE8
                        s_d.rx_valid = 1'b1;
                        s_d.step = 4'h0; // RULE17
                        if (s_q.last_tx == STOP_CHAR_I) begin
                            // Control step halts the timer
                            s_d.mst = M_IDLE; // RULE10 RULE11
                            s_d.busy = 1'b0;
                        end else begin
                            // Next byte without reconfiguring
                            s_d.tx_sh = TX_DATA_I; // RULE7 RULE17
                            s_d.last_tx = TX_DATA_I;
                            s_d.tx_take = 1'b1;
                        end
                    end
                end
            end
            default: begin
                // Illegal code returns to rest
                s_d.mst = M_IDLE;
                s_d.busy = 1'b0;
            end
        endcase
    end

    // ======================================================
    // System domain register
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            s_q.mst <= M_IDLE;
            s_q.tick <= `SPI_TICK_RST;
            s_q.step <= 4'h0;
            s_q.tx_sh <= `SPI_BYTE_RST;
            s_q.last_tx <= `SPI_BYTE_RST;
            s_q.rx_sh <= `SPI_BYTE_RST;
            s_q.sck <= `SPI_CPOL;
            s_q.mosi <= 1'b0;
            s_q.rx_data <= `SPI_BYTE_RST;
            s_q.rx_valid <= 1'b0;
            s_q.tx_take <= 1'b0;
            s_q.busy <= 1'b0;
            s_q.miso_s1 <= 1'b0;
            s_q.miso_s2 <= 1'b0;
            s_q.tgl_s1 <= 1'b0;
            s_q.tgl_s2 <= 1'b0;
            s_q.tgl_s3 <= 1'b0;
            s_q.slv_hold <= `SPI_BYTE_RST;
            s_q.slv_rx <= `SPI_BYTE_RST;
            s_q.slv_rx_valid <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================
    // Outputs straight from the state register
    assign TX_TAKE_O = s_q.tx_take;
    assign RX_DATA_O = s_q.rx_data;
    assign RX_VALID_O = s_q.rx_valid;
    assign BUSY_O = s_q.busy;
    assign MST_SCK_O = s_q.sck;
    assign MST_MOSI_O = s_q.mosi;
    assign SLV_RX_DATA_O = s_q.slv_rx;
    assign SLV_RX_VALID_O = s_q.slv_rx_valid;

endmodule

/* File: core/spi_emu_defs.svh */
// Constants of the pin-level serial interface emulation.
// Assumes a system clock of 250 MHz and an 8-bit frame.
`ifndef SPI_EMU_DEFS_SVH
`define SPI_EMU_DEFS_SVH

// ==========================================================
// Frame layout
`define SPI_FRAME_BITS 8
`define SPI_BIT_CNT_W 3
`define SPI_STEPS_PER_FRAME 5'h10
`define SPI_LAST_STEP 4'hF

// ==========================================================
// Clock mode: phase 1, polarity 0
`define SPI_CPOL 1'b0
`define SPI_CPHA 1'b1

// ==========================================================
// Timing
`define SPI_CLK_SYS_HZ 250000000
`define SPI_STEP_HZ 9600
`define SPI_STEP_CYC (`SPI_CLK_SYS_HZ / `SPI_STEP_HZ)
`define SPI_TICK_W 16

// ==========================================================
// Reset values
`define SPI_BYTE_RST 8'h00
`define SPI_TICK_RST 16'h0000

`endif

/* File: core/spi_emu_pkg.sv */
// Types of the pin-level serial interface emulation.
// Assumes spi_emu_defs.svh is on the include path.
`include "spi_emu_defs.svh"

package spi_emu_pkg;

    // ======================================================
    // Master sequencing states
    typedef enum logic [1:0] {
        M_IDLE = 2'b00, // Timer disabled, clock at rest
        M_RUN = 2'b01   // Timer enabled, steps issued
    } mst_state_t;

    // ======================================================
    // System domain state
    typedef struct packed {
        mst_state_t mst;               // Master sequencer
        logic [`SPI_TICK_W-1:0] tick;  // Timer down counter
        logic [3:0] step;              // Clock step in frame
        logic [7:0] tx_sh;             // Master send shifter
        logic [7:0] last_tx;           // Byte being sent
        logic [7:0] rx_sh;             // Master receive shifter
        logic sck;                     // Master clock pin
        logic mosi;                    // Master data out pin
        logic [7:0] rx_data;           // Master received byte
        logic rx_valid;                // Master byte pulse
        logic tx_take;                 // Master byte taken
        logic busy;                    // Timer running
        logic miso_s1;                 // Input sync stage 1
        logic miso_s2;                 // Input sync stage 2
        logic tgl_s1;                  // Slave done sync 1
        logic tgl_s2;                  // Slave done sync 2
        logic tgl_s3;                  // Slave done edge ref
        logic [7:0] slv_hold;          // Slave send byte
        logic [7:0] slv_rx;            // Slave received byte
        logic slv_rx_valid;            // Slave byte pulse
    } sys_state_t;

    // ======================================================
    // Link domain state, rising edge side
    typedef struct packed {
        logic [7:0] tx_sh;             // Slave send shifter
        logic [2:0] cnt;               // Rising edge count
        logic miso;                    // Slave data out pin
    } link_rise_t;

    // ======================================================
    // Link domain state, falling edge side
    typedef struct packed {
        logic [7:0] rx_sh;             // Slave receive shifter
        logic [2:0] cnt;               // Falling edge count
        logic [7:0] rx_word;           // Last complete byte
        logic done_tgl;                // Flips per frame
    } link_fall_t;

endpackage

/* File: core/spi_emu_slave_link.sv */
// Slave side of the emulated serial link, clocked by the
// external master's serial clock. Assumes the clock stands
// low between frames and each frame has exactly 8 periods.
`include "spi_emu_defs.svh"

module spi_emu_slave_link (
    // Link clock and reset
    input wire logic sck_i,
    input wire logic rst_i,
    // Serial pins
    input wire logic mosi_i,
    output logic miso_o,
    // Parallel side, held stable by the system domain
    input wire logic [7:0] tx_word_i,
    output logic [7:0] rx_word_o,
    output logic done_tgl_o
);
    import spi_emu_pkg::*;

    link_rise_t r_q, r_d; // Rising edge state
    link_fall_t f_q, f_d; // Falling edge state

    // ======================================================
    // Rising edge: transmit step presents the next bit
    always_comb begin
        r_d = r_q;
        if (r_q.cnt == 3'h0) begin
            // First edge of frame loads byte, MSB out first
            r_d.miso = tx_word_i[7]; // RULE14 RULE16
            r_d.tx_sh = {tx_word_i[6:0], 1'b0}; // RULE7
        end else begin
            r_d.miso = r_q.tx_sh[7]; // RULE15
            r_d.tx_sh = {r_q.tx_sh[6:0], 1'b0};
        end
        // Wraps after 8 edges for the next byte
        r_d.cnt = r_q.cnt + 3'h1; // RULE17
    end

    // Registers the rising edge state
    always_ff @(posedge sck_i or posedge rst_i) begin
        if (rst_i) begin
            r_q <= '0;
        end else begin
            r_q <= r_d; // RULE13
        end
    end

    // ======================================================
    // Falling edge: receive step samples the data pin
    always_comb begin
        f_d = f_q;
        f_d.rx_sh = {f_q.rx_sh[6:0], mosi_i}; // RULE15 RULE3
        f_d.cnt = f_q.cnt + 3'h1; // RULE17
        if (f_q.cnt == 3'h7) begin
            // Eighth sample closes the frame
            f_d.rx_word = {f_q.rx_sh[6:0], mosi_i}; // RULE6 RULE8
            f_d.done_tgl = ~f_q.done_tgl;
        end
    end

    // Registers the falling edge state
    always_ff @(negedge sck_i or posedge rst_i) begin
        if (rst_i) begin
            f_q <= '0;
        end else begin
            f_q <= f_d; // RULE13
        end
    end

    assign miso_o = r_q.miso;
    assign rx_word_o = f_q.rx_word;
    assign done_tgl_o = f_q.done_tgl;

endmodule

/* File: dv/spi_emu_props.sv */
// Checker for the pin-level serial emulation, system clock only.
// Assumes it is bound to spi_emu and sees only its ports.
module spi_emu_props #(
    parameter int unsigned STEP_CYCLES = 4
) (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // Master side
    input wire logic START_I,
    input wire logic [7:0] STOP_CHAR_I,
    input wire logic [7:0] TX_DATA_I,
    input wire logic TX_TAKE_O,
    input wire logic [7:0] RX_DATA_O,
    input wire logic RX_VALID_O,
    input wire logic BUSY_O,
    input wire logic MST_SCK_O,
    input wire logic MST_MOSI_O,
    // Slave side
    input wire logic [7:0] SLV_RX_DATA_O,
    input wire logic SLV_RX_VALID_O
);
    // ==========================================================
    // Helper state
    logic [7:0] prev_tx_q; // Data input one cycle back
    logic [7:0] sent_q;    // Byte of the running frame
    logic [3:0] falls_q;   // Falling clock steps in frame

    // Track the byte being sent and its clock falls
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            prev_tx_q <= 8'h00;
            sent_q <= 8'h00;
            falls_q <= 4'h0;
        end else begin
            prev_tx_q <= TX_DATA_I;
            if (TX_TAKE_O) begin
                sent_q <= prev_tx_q;
                falls_q <= 4'h0;
            end else if ($fell(MST_SCK_O)) begin
                falls_q <= falls_q + 4'h1;
            end
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    property p_start;
        !BUSY_O && START_I |=> TX_TAKE_O && BUSY_O;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_idle_low;
        !BUSY_O |-> !MST_SCK_O;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("clock not idle");
    property p_half;
        $rose(MST_SCK_O) |-> ##STEP_CYCLES $fell(MST_SCK_O);
    endproperty
    a_half: assert property (p_half) else $error("clock step rate");
    property p_lead;
        TX_TAKE_O |-> ##STEP_CYCLES $rose(MST_SCK_O);
    endproperty
    a_lead: assert property (p_lead) else $error("first edge late");
    property p_sample_stable;
        $fell(MST_SCK_O) |-> $stable(MST_MOSI_O);
    endproperty
    a_sample_stable: assert property (p_sample_stable) else $error("data moved");
    property p_rx_at_fall;
        RX_VALID_O |-> $fell(MST_SCK_O) && falls_q == 4'h7;
    endproperty
    a_rx_at_fall: assert property (p_rx_at_fall) else $error("frame length");
    property p_next_or_stop;
        RX_VALID_O |-> BUSY_O == (sent_q != STOP_CHAR_I) && TX_TAKE_O == BUSY_O;
    endproperty
    a_next_or_stop: assert property (p_next_or_stop) else $error("stop wrong");
    property p_rx_hold;
        $changed(RX_DATA_O) |-> RX_VALID_O;
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx data moved");
    property p_slv_hold;
        $changed(SLV_RX_DATA_O) |-> SLV_RX_VALID_O;
    endproperty
    a_slv_hold: assert property (p_slv_hold) else $error("slave data moved");
endmodule

bind spi_emu spi_emu_props #(.STEP_CYCLES(STEP_CYCLES)) props_i (
    .CLK_SYS_I, .RST_I, .START_I, .STOP_CHAR_I, .TX_DATA_I, .TX_TAKE_O,
    .RX_DATA_O, .RX_VALID_O, .BUSY_O, .MST_SCK_O, .MST_MOSI_O,
    .SLV_RX_DATA_O, .SLV_RX_VALID_O
);

/* File: dv/spi_partner.sv */
// Far-side model: a plain serial peripheral, slave to the
// design's master and master to the design's slave.
// Assumes the bench calls send() for each slave-side frame.
module spi_partner (
    // Reset
    input wire logic rst_i,
    // Slave role pins and data
    input wire logic m_sck_i,
    input wire logic m_mosi_i,
    output logic m_miso_o,
    input wire logic [7:0] m_reply_i,
    output logic [7:0] m_got_o,
    // Master role pins
    output logic s_sck_o,
    output logic s_mosi_o,
    input wire logic s_miso_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sh; // Receive shifter
    logic [2:0] n;  // Bit index in frame

    // Slave role: drive on rising clock, sample on falling
    always @(posedge m_sck_i or negedge m_sck_i or posedge rst_i) begin
        if (rst_i) begin
            n <= 3'h0;
            m_miso_o <= 1'b0;
            m_got_o <= 8'h00;
        end else if (m_sck_i) begin
            m_miso_o <= m_reply_i[3'h7 - n];
        end else begin
            sh <= {sh[6:0], m_mosi_i};
            n <= n + 3'h1;
            if (n == 3'h7) begin
                m_got_o <= {sh[6:0], m_mosi_i};
                m_miso_o <= ~m_miso_o; // Released line shows no old bit
            end
        end
    end

    // No chip select pin: the caller frames each transfer itself
    initial begin
        s_sck_o = 1'b0;
        s_mosi_o = 1'b0;
    end

    // Master role: 32 ns clock only within the frame
    task automatic send(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            s_sck_o = 1'b1;
            s_mosi_o = b[i];
            #16;
            s_sck_o = 1'b0;
            r[i] = s_miso_i;
            #16;
        end
        s_mosi_o = ~s_mosi_o;
    endtask
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for spi_emu with the far-side model.
// Assumes the checker is bound by its own file.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned STEPS = 4; // Short step timer
    logic clk, rst, start, take, rx_valid, busy, load, slv_valid;
    logic sck_m, mosi_m, miso_m, sck_s, mosi_s, miso_s;
    logic [7:0] stop, tx, rx_data, slv_tx, slv_rx, reply, got;
    int failures, n_compared, cycles;

    // ==========================================================
    // Design and far side
    spi_emu #(.STEP_CYCLES(STEPS)) spi_emu_i (
        .CLK_SYS_I(clk), .RST_I(rst), .START_I(start),
        .STOP_CHAR_I(stop), .TX_DATA_I(tx), .TX_TAKE_O(take),
        .RX_DATA_O(rx_data), .RX_VALID_O(rx_valid), .BUSY_O(busy),
        .MST_SCK_O(sck_m), .MST_MOSI_O(mosi_m), .MST_MISO_I(miso_m),
        .SLV_TX_LOAD_I(load), .SLV_TX_DATA_I(slv_tx),
        .SLV_RX_DATA_O(slv_rx), .SLV_RX_VALID_O(slv_valid),
        .SLV_SCK_I(sck_s), .SLV_MOSI_I(mosi_s), .SLV_MISO_O(miso_s));
    spi_partner spi_partner_i (
        .rst_i(rst), .m_sck_i(sck_m), .m_mosi_i(mosi_m),
        .m_miso_o(miso_m), .m_reply_i(reply), .m_got_o(got),
        .s_sck_o(sck_s), .s_mosi_o(mosi_s), .s_miso_i(miso_s));

    // ==========================================================
    // Compare, wait and closing tasks
    task automatic chk8(input string w, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chk1(input string w, input logic e, input logic g);
        chk8(w, {7'h00, e}, {7'h00, g});
    endtask
    // Step at least one cycle, then until the chosen pulse
    task automatic wait_pulse(input logic slv);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while ((slv ? slv_valid : rx_valid) !== 1'b1 && k < 200);
        // A missing pulse counts as a mismatch
        chk1("valid pulse", 1'b1, slv ? slv_valid : rx_valid);
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    // Two back-to-back master frames, the second the stop byte
    task automatic t_master();
        reply = 8'h96;
        stop = 8'h3C;
        tx = 8'hA5;
        start = 1'b1;
        @(posedge clk);
        #1;
        start = 1'b0;
        chk1("take", 1'b1, take);
        tx = 8'h3C;
        wait_pulse(1'b0);
        chk8("master rx", 8'h96, rx_data);
        chk8("partner got", 8'hA5, got);
        chk1("next take", 1'b1, take);
        reply = 8'h69;
        wait_pulse(1'b0);
        chk8("master rx 2", 8'h69, rx_data);
        chk8("partner got 2", 8'h3C, got);
        chk1("busy at stop", 1'b0, busy);
        repeat (3 * STEPS) @(posedge clk);
        #1;
        chk1("clock rests", 1'b0, sck_m);
    endtask
    // Slave frames from the far-side master
    task automatic t_slave();
        logic [7:0] r;
        logic [7:0] mo [2] = '{8'h5A, 8'h7E};
        logic [7:0] so [2] = '{8'hC3, 8'h81};
        for (int j = 0; j < 2; j++) begin
            // Realign stimulus to just after a system edge
            @(posedge clk);
            #1;
            slv_tx = so[j];
            load = 1'b1;
            @(posedge clk);
            #1;
            load = 1'b0;
            #0.3;
            // Pulse ends before the frame task returns: watch alongside
            fork
                spi_partner_i.send(mo[j], r);
                wait_pulse(1'b1);
            join
            chk8("slave out", so[j], r);
            chk8("slave rx", mo[j], slv_rx);
        end
    endtask

    // ==========================================================
    // Clock, watchdog and main sequence
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        cycles = 0;
        forever begin
            @(posedge clk);
            cycles++;
            if (cycles == 3000) begin
                failures++;
                tally_and_finish();
            end
        end
    end
    initial begin
        {start, load, rst} = 3'h1;
        {stop, tx, slv_tx, reply} = 32'h0;
        failures = 0;
        n_compared = 0;
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        chk1("busy after reset", 1'b0, busy);
        t_master();
        t_slave();
        tally_and_finish();
    end
endmodule
